//--- tb/diag_source_select_checker.sv
// port assertions for the diagnostic source select block
`timescale 1ns/1ps
module diag_source_select_checker
  import diag_select_pkg::*;
(
  input wire logic                     clock_i,        // clock
  input wire logic                     sys_rst_i,      // reset
  input diag_select_pkg::reg_req_s     reg_req_i,      // register request
  input diag_select_pkg::reg_rsp_s     reg_rsp_o,      // register answer
  input wire logic [3:0]               slot_enable_i,  // slot enables
  input diag_select_pkg::conv_req_s    conv_req_i,     // conversion request
  input diag_select_pkg::adc_rsp_s     adc_rsp_i,      // sample return
  input wire logic                     adc_start_o,    // start pulse
  input diag_select_pkg::diag_source_e adc_source_o,   // routed source
  input wire logic [1:0]               active_slot_o,  // converted slot
  input wire logic                     busy_o,         // busy
  input wire logic                     stored_o,       // store pulse
  input wire logic [15:0]              select_value_o  // register contents
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // undefined codes fall back to ground
  function automatic logic [3:0] exp_src(input logic [15:0] v, input logic [1:0] s);
    logic [3:0] c;
    c = v[s*4 +: 4];
    return (c > 4'hD) ? 4'h0 : c;
  endfunction : exp_src
  a_read_answer: assert property (reg_req_i.rd |=> reg_rsp_o.rvalid) else $error("read not answered");
  a_no_spurious: assert property (!reg_req_i.rd |=> !reg_rsp_o.rvalid) else $error("spurious rvalid");
  a_write_applies: assert property (reg_req_i.wr && reg_req_i.addr == diag_select_addr
    |=> select_value_o == $past(reg_req_i.wdata)) else $error("write lost");
  a_other_write: assert property (reg_req_i.wr && reg_req_i.addr != diag_select_addr
    |=> $stable(select_value_o)) else $error("select changed");
  a_read_data: assert property (reg_req_i.rd && reg_req_i.addr == diag_select_addr
    |=> reg_rsp_o.rdata == $past(select_value_o)) else $error("bad read data");
  a_start_cause: assert property (conv_req_i.req && !busy_o && slot_enable_i[conv_req_i.slot]
    |=> adc_start_o && busy_o && active_slot_o == $past(conv_req_i.slot)) else $error("no start");
  a_disabled_slot: assert property (conv_req_i.req && !slot_enable_i[conv_req_i.slot]
    |=> !adc_start_o) else $error("disabled slot started");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o) else $error("long start");
  a_source_decode: assert property (adc_start_o |-> adc_source_o ==
    exp_src($past(select_value_o), active_slot_o)) else $error("wrong source");
  a_done_store: assert property (busy_o && adc_rsp_i.done |=> stored_o && !busy_o) else $error("no store");
  c_write: cover property (reg_req_i.wr && reg_req_i.addr == diag_select_addr);
  c_convert: cover property (adc_start_o ##[1:10] stored_o);
  c_fallback: cover property (adc_start_o && adc_source_o == src_analog_ground);
endmodule : diag_source_select_checker
bind diag_source_select diag_source_select_checker chk_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o), .slot_enable_i(slot_enable_i), .conv_req_i(conv_req_i),
  .adc_rsp_i(adc_rsp_i), .adc_start_o(adc_start_o), .adc_source_o(adc_source_o),
  .active_slot_o(active_slot_o), .busy_o(busy_o), .stored_o(stored_o), .select_value_o(select_value_o));

//--- tb/test_diag_source_select.sv
// self-checking bench for the diagnostic source select block
`timescale 1ns/1ps
module test_diag_source_select;
  import diag_select_pkg::*;
  logic         clock_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  reg_req_s     req = '0;
  reg_rsp_s     rsp;
  logic [3:0]   en = 4'hF;
  conv_req_s    conv = '0;
  adc_rsp_s     adc = '0;
  logic         start, busy, stored;
  diag_source_e src;
  logic [1:0]   slot;
  logic [15:0]  sel, rv, val;
  int           num_errors = 0;
  int           checks = 0;
  int           cycles = 0;
  always #10 clock_i = ~clock_i;
  diag_source_select uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rsp_o(rsp),
    .slot_enable_i(en), .conv_req_i(conv), .adc_rsp_i(adc), .adc_start_o(start), .adc_source_o(src),
    .active_slot_o(slot), .busy_o(busy), .stored_o(stored), .select_value_o(sel));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock_i);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clock_i);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock_i);
    req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(negedge clock_i);
    req.rd = 1'b0;
    chk("rvalid", {15'h0, rsp.rvalid}, 16'h0001);
    d = rsp.rdata;
  endtask : rd
  // one conversion of slot s, expecting source e, returning sample d
  task automatic cnv(input logic [1:0] s, input logic [3:0] e, input logic [15:0] d);
    @(negedge clock_i);
    conv = '{req: 1'b1, slot: s};
    @(negedge clock_i);
    conv.req = 1'b0;
    chk("start busy slot", {12'h0, start, busy, slot}, {12'h0, 2'b11, s});
    chk("source", {12'h0, src}, {12'h0, e});
    @(negedge clock_i);
    adc = '{done: 1'b1, data: d};
    @(negedge clock_i);
    adc.done = 1'b0;
    chk("busy stored", {14'h0, busy, stored}, 16'h0001);
    rd(diag_result_base_addr + 8'(s), rv);
    chk("result", rv, d);
  endtask : cnv
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge clock_i);
    sys_rst_i = 1'b0;
    chk("select reset", sel, diag_select_reset);
    rd(diag_select_addr, rv);
    chk("select read", rv, 16'h0000);
    cnv(2'h3, 4'h0, 16'hA5C3);
    wr(8'h2D, 16'h1234);
    rd(8'h2D, rv);
    chk("result read only", rv, 16'hA5C3);
    wr(8'h25, 16'hFFFF);
    rd(8'h25, rv);
    chk("unmapped", rv, 16'h0000);
    chk("select kept", sel, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      for (int s = 0; s < 4; s++) begin
        val = {4{4'(15 - c)}};
        val[s*4 +: 4] = 4'(c);
        wr(diag_select_addr, val);
        rd(diag_select_addr, rv);
        chk("select", rv, val);
        cnv(2'(s), (c > 13) ? 4'h0 : 4'(c), {4'(s), 12'(c)});
      end
    end
    en = 4'h7;
    @(negedge clock_i);
    conv = '{req: 1'b1, slot: 2'h3};
    @(negedge clock_i);
    conv.req = 1'b0;
    chk("disabled slot", {14'h0, start, busy}, 16'h0000);
    print_verdict();
  end
endmodule : test_diag_source_select

//--- verilog/diag_result_bank.sv
// four diagnostic result words, one per slot
`timescale 1ns/1ps
module diag_result_bank
  import diag_select_pkg::*;
(
  input  wire logic        clock_i,    // system clock
  input  wire logic        sys_rst_i,  // synchronous reset, active high
  input  wire logic        wr_en_i,    // store a sample
  input  wire logic [1:0]  wr_slot_i,  // slot receiving the sample
  input  wire logic [15:0] wr_data_i,  // sample value
  input  wire logic [1:0]  rd_slot_i,  // slot being read
  output logic      [15:0] rd_data_o   // stored sample of rd_slot_i
);
  import diag_select_pkg::*;

  logic [15:0] result_mem [slot_count];

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < slot_count; i++) begin
        result_mem[i] <= diag_result_reset;
      end
    end else if (wr_en_i) begin
      result_mem[wr_slot_i] <= wr_data_i;
    end
  end

  assign rd_data_o = result_mem[rd_slot_i];

endmodule : diag_result_bank

//--- verilog/diag_select_pkg.sv
// constants, types and field helpers shared by the diagnostic source select block
package diag_select_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0]  diag_select_addr      = 8'h24;
  localparam logic [7:0]  diag_result_base_addr = 8'h2A;
  localparam logic [7:0]  diag_result_last_addr = 8'h2D;
  localparam logic [15:0] diag_select_reset     = 16'h0000;
  localparam logic [15:0] diag_result_reset     = 16'h0000;
  localparam logic [15:0] unmapped_read_value   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // selector field layout
  localparam int selector_width = 4;
  localparam int slot_count     = 4;
  localparam int slot0_sel_lsb  = 0;
  localparam int slot1_sel_lsb  = 4;
  localparam int slot2_sel_lsb  = 8;
  localparam int slot3_sel_lsb  = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // source encodings
  typedef enum logic [3:0] {
    src_analog_ground          = 4'h0,
    src_temperature_sensor     = 4'h1,
    src_analog_supply_pin      = 4'h2,
    src_negative_pump_voltage  = 4'h3,
    src_reference_output_pin   = 4'h4,
    src_analog_regulator_5v    = 4'h5,
    src_analog_regulator_1v8   = 4'h6,
    src_digital_regulator_1v8  = 4'h7,
    src_digital_core_supply    = 4'h8,
    src_interface_logic_supply = 4'h9,
    src_terminal_sense_a       = 4'hA,
    src_terminal_sense_b       = 4'hB,
    src_terminal_sense_c       = 4'hC,
    src_terminal_sense_d       = 4'hD
  } diag_source_e;

  typedef enum logic [1:0] {
    phase_idle    = 2'b00,
    phase_convert = 2'b01
  } conv_phase_e;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic [15:0] rdata;
    logic        rvalid;
  } reg_rsp_s;

  typedef struct packed {
    logic       req;
    logic [1:0] slot;
  } conv_req_s;

  typedef struct packed {
    logic        done;
    logic [15:0] data;
  } adc_rsp_s;

  typedef struct packed {
    conv_phase_e  phase;
    logic [15:0]  select;
    logic [1:0]   slot;
    diag_source_e source;
    logic         adc_start;
    logic         busy;
    logic         stored;
    reg_rsp_s     rsp;
  } diag_state_s;

  localparam diag_state_s state_reset = '{
    phase:     phase_idle,
    select:    diag_select_reset,
    slot:      2'h0,
    source:    src_analog_ground,
    adc_start: 1'b0,
    busy:      1'b0,
    stored:    1'b0,
    rsp:       '{rdata: 16'h0000, rvalid: 1'b0}
  };

  ////////////////////////////////////////////////////////////////////////////////
  // field extraction
  function automatic logic [3:0] selector_of(input logic [15:0] value, input logic [1:0] slot);
    logic [3:0] field;
    field = value[slot0_sel_lsb +: selector_width];
    case (slot)
      2'h3: field = value[slot3_sel_lsb +: selector_width];
      2'h2: field = value[slot2_sel_lsb +: selector_width];
      2'h1: field = value[slot1_sel_lsb +: selector_width];
      default: field = value[slot0_sel_lsb +: selector_width];
    endcase
    return field;
  endfunction : selector_of

  function automatic logic is_result_addr(input logic [7:0] addr);
    return (addr >= diag_result_base_addr) && (addr <= diag_result_last_addr);
  endfunction : is_result_addr

endpackage : diag_select_pkg

//--- verilog/diag_source_decoder.sv
// maps a 4-bit selector code onto the routed diagnostic source
`timescale 1ns/1ps
module diag_source_decoder
  import diag_select_pkg::*;
(
  input  wire logic [3:0]                  code_i,   // selector field value
  output diag_select_pkg::diag_source_e    source_o  // decoded source
);
  import diag_select_pkg::*;

  always_comb begin
    case (code_i)
      4'h0: source_o = src_analog_ground;
      4'h1: source_o = src_temperature_sensor;
      4'h2: source_o = src_analog_supply_pin;
      4'h3: source_o = src_negative_pump_voltage;
      4'h4: source_o = src_reference_output_pin;
      4'h5: source_o = src_analog_regulator_5v;
      4'h6: source_o = src_analog_regulator_1v8;
      4'h7: source_o = src_digital_regulator_1v8;
      4'h8: source_o = src_digital_core_supply;
      4'h9: source_o = src_interface_logic_supply;
      4'hA: source_o = src_terminal_sense_a;
      4'hB: source_o = src_terminal_sense_b;
      4'hC: source_o = src_terminal_sense_c;
      4'hD: source_o = src_terminal_sense_d;
      default: source_o = src_analog_ground;
    endcase
  end

endmodule : diag_source_decoder

//--- verilog/diag_source_select.sv
// diagnostic source select register with slot conversion steering
//
// Overview of operation
// - 16-bit RW register at 0x24, resets zero
// - bits 15:12 select slot 3 source
// - bits 11:8 select slot 2 source
// - bits 7:4 select slot 1 source
// - bits 3:0 select slot 0 source
// - codes 0-3: ground, temperature, supply, pump
// - codes 4-7: reference, 5V, 1.8V analog, digital
// - codes 8-9: core supply, interface supply
// - codes A-D: terminal sense channels A-D
// - codes E and F fall back to ground
// - all fields readable, writable, reset to zero
// - slot converts only when its enable set
`timescale 1ns/1ps
module diag_source_select
  import diag_select_pkg::*;
(
  input  wire logic                       clock_i,        // system clock, 50 MHz
  input  wire logic                       sys_rst_i,      // synchronous reset, active high
  input  diag_select_pkg::reg_req_s       reg_req_i,      // register access request
  output diag_select_pkg::reg_rsp_s       reg_rsp_o,      // register read answer
  input  wire logic [3:0]                 slot_enable_i,  // per-slot conversion enables
  input  diag_select_pkg::conv_req_s      conv_req_i,     // sequencer asks for a slot conversion
  input  diag_select_pkg::adc_rsp_s       adc_rsp_i,      // converter sample return
  output logic                            adc_start_o,    // one-cycle conversion start
  output diag_select_pkg::diag_source_e   adc_source_o,   // source routed to the converter
  output logic [1:0]                      active_slot_o,  // slot being converted
  output logic                            busy_o,         // conversion in flight
  output logic                            stored_o,       // one-cycle pulse after a result store
  output logic [15:0]                     select_value_o  // current register contents
);
  import diag_select_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  diag_state_s  state_reg;
  diag_state_s  state_next;
  diag_source_e start_source;
  logic [3:0]   start_code;
  logic [15:0]  bank_rd_data;
  logic [1:0]   bank_rd_slot;
  logic         bank_wr_en;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  // the selector is sampled when the conversion starts, so a later write cannot
  // disturb a sample already in flight
  assign start_code   = selector_of(state_reg.select, conv_req_i.slot);
  assign bank_rd_slot = 2'(reg_req_i.addr - diag_result_base_addr);
  assign bank_wr_en   = (state_reg.phase == phase_convert) && adc_rsp_i.done;

  diag_source_decoder u_decoder (
    .code_i   (start_code),
    .source_o (start_source)
  );

  diag_result_bank u_results (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (bank_wr_en),
    .wr_slot_i (state_reg.slot),
    .wr_data_i (adc_rsp_i.data),
    .rd_slot_i (bank_rd_slot),
    .rd_data_o (bank_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next            = state_reg;
    state_next.adc_start  = 1'b0;
    state_next.stored     = 1'b0;
    state_next.rsp.rvalid = 1'b0;

    if (reg_req_i.wr) begin
      if (reg_req_i.addr == diag_select_addr) begin
        state_next.select = reg_req_i.wdata;
      end
    end

    if (reg_req_i.rd) begin
      state_next.rsp.rvalid = 1'b1;
      if (reg_req_i.addr == diag_select_addr) begin
        state_next.rsp.rdata = state_reg.select;
      end else if (is_result_addr(reg_req_i.addr)) begin
        state_next.rsp.rdata = bank_rd_data;
      end else begin
        state_next.rsp.rdata = unmapped_read_value;
      end
    end

    case (state_reg.phase)
      phase_idle: begin
        if (conv_req_i.req && slot_enable_i[conv_req_i.slot]) begin
          state_next.phase     = phase_convert;
          state_next.slot      = conv_req_i.slot;
          state_next.source    = start_source;
          state_next.adc_start = 1'b1;
          state_next.busy      = 1'b1;
        end
      end
      phase_convert: begin
        if (adc_rsp_i.done) begin
          state_next.phase  = phase_idle;
          state_next.busy   = 1'b0;
          state_next.stored = 1'b1;
        end
      end
      default: begin
        state_next.phase = phase_idle;
        state_next.busy  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= state_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rsp_o      = state_reg.rsp;
  assign adc_start_o    = state_reg.adc_start;
  assign adc_source_o   = state_reg.source;
  assign active_slot_o  = state_reg.slot;
  assign busy_o         = state_reg.busy;
  assign stored_o       = state_reg.stored;
  assign select_value_o = state_reg.select;

endmodule : diag_source_select
